// file: rtl/pcosp_regs.vh
`ifndef PCOSP_REGS_VH
`define PCOSP_REGS_VH

// counter width and special counter values
`define PCOSP_CNT_W         16
`define PCOSP_CNT_ZERO      16'h0000
`define PCOSP_CNT_ONE       16'h0001
`define PCOSP_CNT_ALL_ONES  16'hFFFF
`define PCOSP_DATA_RST      16'h0000

// count clock divider: one tick every DIV_LAST+1 operating clocks
`define PCOSP_DIV_W         4
`define PCOSP_DIV_ZERO      4'h0
`define PCOSP_DIV_ONE       4'h1
`define PCOSP_DIV_LAST      4'h3

// output role select encoding
`define PCOSP_ROLE_MASTER   1'b0
`define PCOSP_ROLE_SLAVE    1'b1

// input edge select encoding
`define PCOSP_EDGE_FALL     2'h0
`define PCOSP_EDGE_RISE     2'h1
`define PCOSP_EDGE_BOTH     2'h2
`define PCOSP_EDGE_BOTH_ALT 2'h3

// channel numbers
`define PCOSP_MASTER_CH_LO  2'h0
`define PCOSP_MASTER_CH_HI  2'h2
`define PCOSP_SLAVE_CH_LO   2'h1
`define PCOSP_SLAVE_CH_HI   2'h3
`define PCOSP_SLAVE_CH_TWO  2'h3

`endif

// file: rtl/pcosp_edge_det.v
`timescale 1ns/1ps
`include "pcosp_regs.vh"

module pcosp_edge_det (
    // clock and reset
    input  wire       i_clk,
    input  wire       i_reset_n,
    // control
    input  wire       i_clear,
    input  wire [1:0] i_edge_sel,
    // pin
    input  wire       i_pin,
    // result
    output reg        o_edge
);

    reg sample_reg;
    reg prev_reg;
    reg edge_next;

    always @* begin
        case (i_edge_sel)
            `PCOSP_EDGE_FALL: edge_next = prev_reg & ~sample_reg;
            `PCOSP_EDGE_RISE: edge_next = ~prev_reg & sample_reg;
            default:          edge_next = prev_reg ^ sample_reg;
        endcase
    end

    // pin sampled on the operating clock
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sample_reg <= 1'b0;
            prev_reg   <= 1'b0;
            o_edge     <= 1'b0;
        end else if (i_clear) begin
            sample_reg <= 1'b0;
            prev_reg   <= 1'b0;
            o_edge     <= 1'b0;
        end else begin
            sample_reg <= i_pin;
            prev_reg   <= sample_reg;
            o_edge     <= edge_next;
        end
    end

endmodule // pcosp_edge_det

// file: rtl/pcosp_pair.v
//
// Contract
// - start both trigger bits together; flags set
// - enabled master waits trigger, loads, counts down
// - master zero raises irq, parks all ones
// - plain mode slave starts on master irq
// - output active one tick later, off at zero
// - stop clears flags; counters and pin hold
// - output disabled: pin drives software level bit
// - enabled but stopped: level writes leave pin
// - role bit zero master, one slave output
// - power off stops clock, resets, ignores writes
// - master is channel 0 or 2, slave 1 or 3
// - two-input delay is master data plus two
// - width is capture plus one, plus overflow
// - input pins sampled on operating clock
// - two-input master zero drives output active
// - slave edge captures, clears, irq, output off
// - capture sets or clears overflow flag
// - overflow flag records only that one happened
// - software start acts as master trigger
`timescale 1ns/1ps
`include "pcosp_regs.vh"

module pcosp_pair (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset_n,
    // unit control
    input  wire        i_unit_power_enable,
    input  wire        i_master_sel,
    input  wire        i_two_input_mode,
    // trigger bit write pulses
    input  wire        i_start_master,
    input  wire        i_start_slave,
    input  wire        i_stop_master,
    input  wire        i_stop_slave,
    // channel modes
    input  wire        i_master_role,
    input  wire        i_slave_role,
    input  wire [1:0]  i_master_edge_sel,
    input  wire [1:0]  i_slave_edge_sel,
    // data register writes
    input  wire [15:0] i_master_data,
    input  wire        i_master_data_we,
    input  wire [15:0] i_slave_data,
    input  wire        i_slave_data_we,
    // output control
    input  wire        i_output_enable,
    input  wire        i_output_level,
    input  wire        i_output_level_we,
    input  wire        i_level_invert,
    // timer input pins
    input  wire        i_master_input_pin,
    input  wire        i_slave_input_pin,
    // status
    output wire        o_master_enabled,
    output wire        o_slave_enabled,
    output wire [15:0] o_master_count,
    output wire [15:0] o_slave_count,
    output wire [15:0] o_master_data,
    output wire [15:0] o_slave_data,
    output wire        o_overflow_flag,
    output wire [1:0]  o_master_index,
    output wire [1:0]  o_slave_index,
    // events
    output wire        o_master_done_irq,
    output wire        o_slave_done_irq,
    // pulse output pin
    output wire        o_pulse_output_pin
);

    localparam M_WAIT  = 2'h0;
    localparam M_LOAD  = 2'h1;
    localparam M_COUNT = 2'h2;

    localparam S_IDLE  = 2'h0;
    localparam S_LOAD  = 2'h1;
    localparam S_DOWN  = 2'h2;
    localparam S_UP    = 2'h3;

    function [15:0] pcosp_step;
        input [15:0] cnt;
        input        up;
        begin
            if (up) begin
                pcosp_step = cnt + `PCOSP_CNT_ONE;
            end else begin
                pcosp_step = cnt - `PCOSP_CNT_ONE;
            end
        end
    endfunction

    reg  [3:0]  div_reg;
    reg         tick_reg;
    reg         master_en_reg;
    reg         slave_en_reg;
    reg  [1:0]  m_state_reg;
    reg  [1:0]  s_state_reg;
    reg  [15:0] m_cnt_reg;
    reg  [15:0] s_cnt_reg;
    reg  [15:0] m_data_reg;
    reg  [15:0] s_data_reg;
    reg         m_irq_reg;
    reg         s_irq_reg;
    reg         ovf_pend_reg;
    reg         ovf_reg;
    reg         sw_level_reg;
    reg         pin_reg;
    reg  [1:0]  m_idx_reg;
    reg  [1:0]  s_idx_reg;

    wire        clr;
    wire        m_edge;
    wire        s_edge;
    wire        m_trig;
    wire        s_go;
    wire        act_level;
    wire        sw_level_now;

    // power off holds everything but the channel numbers at initial values
    assign clr = ~i_unit_power_enable;

    assign act_level    = ~i_level_invert;
    assign sw_level_now = i_output_level_we ? i_output_level : sw_level_reg;

    assign o_master_enabled   = master_en_reg;
    assign o_slave_enabled    = slave_en_reg;
    assign o_master_count     = m_cnt_reg;
    assign o_slave_count      = s_cnt_reg;
    assign o_master_data      = m_data_reg;
    assign o_slave_data       = s_data_reg;
    assign o_overflow_flag    = ovf_reg;
    assign o_master_index     = m_idx_reg;
    assign o_slave_index      = s_idx_reg;
    assign o_master_done_irq  = m_irq_reg;
    assign o_slave_done_irq   = s_irq_reg;
    assign o_pulse_output_pin = pin_reg;

    // pins sampled on the operating clock
    pcosp_edge_det u_master_edge (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_clear    (clr),
        .i_edge_sel (i_master_edge_sel),
        .i_pin      (i_master_input_pin),
        .o_edge     (m_edge)
    );

    pcosp_edge_det u_slave_edge (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_clear    (clr),
        .i_edge_sel (i_slave_edge_sel),
        .i_pin      (i_slave_input_pin),
        .o_edge     (s_edge)
    );

    // start trigger: pin edge or software start while enabled
    assign m_trig = master_en_reg & (m_edge | i_start_master) &
                    (i_master_role == `PCOSP_ROLE_MASTER);

    // slave starts from the master completion event
    assign s_go = m_irq_reg & slave_en_reg &
                  (i_slave_role == `PCOSP_ROLE_SLAVE);

    // count clock enable divider, stopped while powered off
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_reg  <= `PCOSP_DIV_ZERO;
            tick_reg <= 1'b0;
        end else if (clr) begin
            div_reg  <= `PCOSP_DIV_ZERO;
            tick_reg <= 1'b0;
        end else if (div_reg == `PCOSP_DIV_LAST) begin
            div_reg  <= `PCOSP_DIV_ZERO;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + `PCOSP_DIV_ONE;
            tick_reg <= 1'b0;
        end
    end

    // channel numbers of the pair
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            m_idx_reg <= `PCOSP_MASTER_CH_LO;
            s_idx_reg <= `PCOSP_SLAVE_CH_LO;
        end else begin
            m_idx_reg <= i_master_sel ? `PCOSP_MASTER_CH_HI : `PCOSP_MASTER_CH_LO;
            if (i_two_input_mode) begin
                s_idx_reg <= `PCOSP_SLAVE_CH_TWO;
            end else begin
                s_idx_reg <= i_master_sel ? `PCOSP_SLAVE_CH_HI : `PCOSP_SLAVE_CH_LO;
            end
        end
    end

    // enabled flags: set by start, cleared by stop
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            master_en_reg <= 1'b0;
            slave_en_reg  <= 1'b0;
        end else if (clr) begin
            master_en_reg <= 1'b0;
            slave_en_reg  <= 1'b0;
        end else begin
            if (i_stop_master) begin
                master_en_reg <= 1'b0;
            end else if (i_start_master) begin
                master_en_reg <= 1'b1;
            end
            if (i_stop_slave) begin
                slave_en_reg <= 1'b0;
            end else if (i_start_slave) begin
                slave_en_reg <= 1'b1;
            end
        end
    end

    // master channel: one-count delay counter
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            m_state_reg <= M_WAIT;
            m_cnt_reg   <= `PCOSP_CNT_ZERO;
            m_data_reg  <= `PCOSP_DATA_RST;
            m_irq_reg   <= 1'b0;
        end else if (clr) begin
            m_state_reg <= M_WAIT;
            m_cnt_reg   <= `PCOSP_CNT_ZERO;
            m_data_reg  <= `PCOSP_DATA_RST;
            m_irq_reg   <= 1'b0;
        end else begin
            m_irq_reg <= 1'b0;
            if (i_master_data_we) begin
                m_data_reg <= i_master_data;
            end
            if (i_stop_master) begin
                m_state_reg <= M_WAIT;
            end else begin
                case (m_state_reg)
                    M_WAIT: begin
                        if (m_trig) begin
                            m_state_reg <= M_LOAD;
                        end
                    end
                    M_LOAD: begin
                        if (tick_reg) begin
                            m_cnt_reg   <= m_data_reg;
                            m_state_reg <= M_COUNT;
                        end
                    end
                    M_COUNT: begin
                        if (tick_reg) begin
                            if (m_cnt_reg == `PCOSP_CNT_ZERO) begin
                                m_irq_reg   <= 1'b1;
                                m_cnt_reg   <= `PCOSP_CNT_ALL_ONES;
                                m_state_reg <= M_WAIT;
                            end else begin
                                m_cnt_reg <= pcosp_step(m_cnt_reg, 1'b0);
                            end
                        end
                    end
                    default: begin
                        m_state_reg <= M_WAIT;
                    end
                endcase
            end
        end
    end

    // slave channel: pulse width counter or width capture, plus output pin
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_state_reg  <= S_IDLE;
            s_cnt_reg    <= `PCOSP_CNT_ZERO;
            s_data_reg   <= `PCOSP_DATA_RST;
            s_irq_reg    <= 1'b0;
            ovf_pend_reg <= 1'b0;
            ovf_reg      <= 1'b0;
            sw_level_reg <= 1'b0;
            pin_reg      <= 1'b0;
        end else if (clr) begin
            s_state_reg  <= S_IDLE;
            s_cnt_reg    <= `PCOSP_CNT_ZERO;
            s_data_reg   <= `PCOSP_DATA_RST;
            s_irq_reg    <= 1'b0;
            ovf_pend_reg <= 1'b0;
            ovf_reg      <= 1'b0;
            sw_level_reg <= 1'b0;
            pin_reg      <= 1'b0;
        end else begin
            s_irq_reg <= 1'b0;
            if (i_slave_data_we) begin
                s_data_reg <= i_slave_data;
            end
            if (i_output_level_we) begin
                sw_level_reg <= i_output_level;
            end
            if (i_stop_slave) begin
                s_state_reg <= S_IDLE;
            end else begin
                case (s_state_reg)
                    S_IDLE: begin
                        if (s_go) begin
                            s_state_reg <= S_LOAD;
                        end
                    end
                    S_LOAD: begin
                        if (tick_reg) begin
                            if (i_output_enable) begin
                                pin_reg <= act_level;
                            end
                            if (i_two_input_mode) begin
                                s_cnt_reg    <= `PCOSP_CNT_ZERO;
                                ovf_pend_reg <= 1'b0;
                                s_state_reg  <= S_UP;
                            end else begin
                                s_cnt_reg   <= s_data_reg;
                                s_state_reg <= S_DOWN;
                            end
                        end
                    end
                    S_DOWN: begin
                        if (tick_reg) begin
                            if (s_cnt_reg == `PCOSP_CNT_ZERO) begin
                                s_irq_reg   <= 1'b1;
                                s_cnt_reg   <= `PCOSP_CNT_ALL_ONES;
                                s_state_reg <= S_IDLE;
                                if (i_output_enable) begin
                                    pin_reg <= ~act_level;
                                end
                            end else begin
                                s_cnt_reg <= pcosp_step(s_cnt_reg, 1'b0);
                            end
                        end
                    end
                    S_UP: begin
                        if (s_edge) begin
                            s_data_reg   <= s_cnt_reg;
                            s_cnt_reg    <= `PCOSP_CNT_ZERO;
                            s_irq_reg    <= 1'b1;
                            ovf_reg      <= ovf_pend_reg;
                            ovf_pend_reg <= 1'b0;
                            s_state_reg  <= S_IDLE;
                            if (i_output_enable) begin
                                pin_reg <= ~act_level;
                            end
                        end else if (tick_reg) begin
                            s_cnt_reg <= pcosp_step(s_cnt_reg, 1'b1);
                            if (s_cnt_reg == `PCOSP_CNT_ALL_ONES) begin
                                ovf_pend_reg <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        s_state_reg <= S_IDLE;
                    end
                endcase
            end
            // output disabled: pin follows the software level bit
            if (!i_output_enable) begin
                pin_reg <= sw_level_now;
            end
        end
    end

endmodule // pcosp_pair

// file: verif/pcosp_pin_model.sv
`timescale 1ns/1ps
module pcosp_pin_model (
    // clock
    input  wire i_clk,
    // edge requests
    input  wire i_go_master,
    input  wire i_go_slave,
    // timer input pins
    output reg  o_master_pin,
    output reg  o_slave_pin
);
    reg [3:0] hold_m;
    reg [3:0] hold_s;
    initial begin
        hold_m = 4'h0;
        hold_s = 4'h0;
        o_master_pin = 1'b0;
        o_slave_pin = 1'b0;
    end
    // a request gives one rising edge held for eight clocks
    always @(posedge i_clk) begin
        hold_m <= i_go_master ? 4'h8 : (hold_m != 4'h0 ? hold_m - 4'h1 : 4'h0);
        hold_s <= i_go_slave ? 4'h8 : (hold_s != 4'h0 ? hold_s - 4'h1 : 4'h0);
        o_master_pin <= i_go_master || hold_m > 4'h1;
        o_slave_pin <= i_go_slave || hold_s > 4'h1;
    end
endmodule // pcosp_pin_model

// file: verif/pcosp_pair_monitor.sv
`timescale 1ns/1ps
module pcosp_pair_monitor (
    // clock and reset
    input wire        i_clk,
    input wire        i_reset_n,
    // controls
    input wire        i_unit_power_enable,
    input wire        i_master_sel,
    input wire        i_two_input_mode,
    input wire        i_start_master,
    input wire        i_stop_master,
    input wire        i_slave_role,
    input wire        i_output_enable,
    input wire        i_level_invert,
    // outputs
    input wire        o_master_enabled,
    input wire        o_slave_enabled,
    input wire [15:0] o_master_count,
    input wire [15:0] o_slave_count,
    input wire [15:0] o_master_data,
    input wire [1:0]  o_master_index,
    input wire [1:0]  o_slave_index,
    input wire        o_master_done_irq,
    input wire        o_slave_done_irq,
    input wire        o_pulse_output_pin
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire pw  = i_unit_power_enable;
    wire act = !i_level_invert;
    sequence s_fire;
        o_master_done_irq && o_slave_enabled && i_slave_role && i_output_enable && pw;
    endsequence
    sequence s_shown;
        ##[1:5] (o_pulse_output_pin == act);
    endsequence
    chk_irq_single: assert property (o_master_done_irq |=> !o_master_done_irq)
        else $error("master irq longer than one cycle");
    chk_park_ones: assert property (o_master_done_irq |-> o_master_count == 16'hFFFF)
        else $error("master count not parked at all ones");
    chk_slave_rise: assert property (s_fire |-> s_shown)
        else $error("pulse pin not active after master irq");
    chk_slave_end: assert property (o_slave_done_irq && i_output_enable |-> o_pulse_output_pin != act)
        else $error("pulse pin still active at slave irq");
    chk_slave_park: assert property (o_slave_done_irq |-> o_slave_count == (i_two_input_mode ? 16'h0000 : 16'hFFFF))
        else $error("slave count wrong at slave irq");
    chk_start_flag: assert property (i_start_master && !i_stop_master && pw |=> o_master_enabled)
        else $error("master flag not set by start");
    chk_stop_flag: assert property (i_stop_master && pw |=> !o_master_enabled)
        else $error("master flag not cleared by stop");
    chk_stop_hold: assert property ((!o_master_enabled && !o_slave_enabled && pw) ##1 pw
        |-> $stable(o_master_count) && $stable(o_slave_count)) else $error("stopped counter moved");
    chk_pin_hold: assert property ((!o_slave_enabled && i_output_enable && pw) ##1 pw
        |-> $stable(o_pulse_output_pin)) else $error("stopped pin moved");
    chk_power_off: assert property (!pw |=> o_master_count == 16'h0000 && !o_master_enabled
        && !o_slave_enabled && !o_pulse_output_pin && o_master_data == 16'h0000) else $error("power off kept state");
    chk_index_map: assert property (pw ##1 pw |-> o_master_index == ($past(i_master_sel) ? 2'h2 : 2'h0)
        && o_slave_index == (($past(i_two_input_mode) || $past(i_master_sel)) ? 2'h3 : 2'h1))
        else $error("channel index wrong");
endmodule // pcosp_pair_monitor

bind pcosp_pair pcosp_pair_monitor u_mon (.i_clk, .i_reset_n, .i_unit_power_enable, .i_master_sel,
    .i_two_input_mode, .i_start_master, .i_stop_master, .i_slave_role, .i_output_enable, .i_level_invert,
    .o_master_enabled, .o_slave_enabled, .o_master_count, .o_slave_count, .o_master_data, .o_master_index,
    .o_slave_index, .o_master_done_irq, .o_slave_done_irq, .o_pulse_output_pin);

// file: verif/pcosp_pair_bench.sv
`timescale 1ns/1ps
module pcosp_pair_bench;
    logic        i_clk, i_reset_n, i_unit_power_enable, i_master_sel, i_two_input_mode;
    logic        i_start_master, i_start_slave, i_stop_master, i_stop_slave, i_master_role, i_slave_role;
    logic [1:0]  i_master_edge_sel, i_slave_edge_sel;
    logic [15:0] i_master_data, i_slave_data, held;
    logic        i_master_data_we, i_slave_data_we, i_output_enable, i_output_level, i_output_level_we;
    logic        i_level_invert, go_m, go_s;
    wire         i_master_input_pin, i_slave_input_pin, o_master_enabled, o_slave_enabled, o_overflow_flag;
    wire         o_master_done_irq, o_slave_done_irq, o_pulse_output_pin;
    wire  [15:0] o_master_count, o_slave_count, o_master_data, o_slave_data;
    wire  [1:0]  o_master_index, o_slave_index;
    int          n_fail, check_count, cyc, d, w, k;
    logic [15:0] rm [3] = '{16'h0000, 16'h0003, 16'h0007};
    logic [15:0] rs [3] = '{16'h0001, 16'h0000, 16'h0004};
    logic        rsel [3] = '{1'b0, 1'b1, 1'b0};

    pcosp_pair dut (.i_clk, .i_reset_n, .i_unit_power_enable, .i_master_sel, .i_two_input_mode, .i_start_master,
        .i_start_slave, .i_stop_master, .i_stop_slave, .i_master_role, .i_slave_role, .i_master_edge_sel,
        .i_slave_edge_sel, .i_master_data, .i_master_data_we, .i_slave_data, .i_slave_data_we, .i_output_enable,
        .i_output_level, .i_output_level_we, .i_level_invert, .i_master_input_pin, .i_slave_input_pin,
        .o_master_enabled, .o_slave_enabled, .o_master_count, .o_slave_count, .o_master_data, .o_slave_data,
        .o_overflow_flag, .o_master_index, .o_slave_index, .o_master_done_irq, .o_slave_done_irq,
        .o_pulse_output_pin);
    pcosp_pin_model u_pins (.i_clk, .i_go_master(go_m), .i_go_slave(go_s), .o_master_pin(i_master_input_pin),
        .o_slave_pin(i_slave_input_pin));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            close_out;
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task wait_n(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // trigger bits are one-clock write pulses; each start and stop bit follows its own argument
    task strobe(input logic sm, input logic ss, input logic tm, input logic ts);
        @(posedge i_clk);
        {i_start_master, i_start_slave, i_stop_master, i_stop_slave} <= {sm, ss, tm, ts};
        @(posedge i_clk);
        {i_start_master, i_start_slave, i_stop_master, i_stop_slave} <= 4'h0;
        @(negedge i_clk);
    endtask
    // data only rewritten while the pair is stopped
    task setup(input logic [15:0] m, input logic [15:0] s);
        @(posedge i_clk);
        {i_master_data, i_slave_data, i_master_data_we, i_slave_data_we} <= {m, s, 2'b11};
        @(posedge i_clk);
        {i_master_data_we, i_slave_data_we} <= 2'b00;
    endtask
    task measure;
        d = 0;
        w = 0;
        while (o_pulse_output_pin !== 1'b1 && d < 2000) begin
            @(negedge i_clk);
            d++;
        end
        while (o_pulse_output_pin === 1'b1 && w < 2000) begin
            @(negedge i_clk);
            w++;
        end
    endtask

    initial begin
        {i_reset_n, i_master_sel, i_two_input_mode, i_start_master, i_start_slave, i_stop_master} = 6'h00;
        {i_stop_slave, i_master_role, i_master_data_we, i_slave_data_we, i_output_level} = 5'h00;
        {i_output_level_we, i_level_invert, go_m, go_s} = 4'h0;
        {i_unit_power_enable, i_slave_role, i_output_enable} = 3'b111;
        {i_master_edge_sel, i_slave_edge_sel} = {2'h1, 2'h1};
        {i_master_data, i_slave_data} = 32'h0;
        {n_fail, check_count, cyc} = 0;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wait_n(2);
        check(16'(o_pulse_output_pin), 16'h0000);
        for (k = 0; k < 3; k++) begin
            @(posedge i_clk);
            i_master_sel <= rsel[k];
            setup(rm[k], rs[k]);
            strobe(1, 1, 0, 0);
            check(16'(o_master_enabled && o_slave_enabled), 16'h0001);
            strobe(1, 0, 0, 0);
            measure;
            check(16'(d >= 4 * (rm[k] + 2) && d <= 4 * (rm[k] + 3)), 16'h0001);
            check(16'(w), 16'(4 * (rs[k] + 1)));
            check(o_master_count, 16'hFFFF);
            check(o_slave_count, 16'hFFFF);
            strobe(0, 0, 1, 1);
            check(16'(o_master_enabled || o_slave_enabled), 16'h0000);
        end
        setup(16'h0040, 16'h0001);
        strobe(1, 1, 0, 0);
        strobe(1, 0, 0, 0);
        wait_n(20);
        strobe(0, 0, 1, 1);
        held = o_master_count;
        wait_n(12);
        check(o_master_count, held);
        check(16'(held < 16'h0040), 16'h0001);
        @(posedge i_clk);
        {i_output_enable, i_output_level, i_output_level_we} <= 3'b011;
        @(posedge i_clk);
        i_output_level_we <= 1'b0;
        wait_n(4);
        check(16'(o_pulse_output_pin), 16'h0001);
        @(posedge i_clk);
        {i_output_enable, i_output_level, i_output_level_we} <= 3'b101;
        @(posedge i_clk);
        i_output_level_we <= 1'b0;
        wait_n(4);
        check(16'(o_pulse_output_pin), 16'h0001);
        @(posedge i_clk);
        i_master_role <= 1'b1;
        strobe(1, 1, 0, 0);
        strobe(1, 0, 0, 0);
        wait_n(40);
        check(o_master_count, held);
        strobe(0, 0, 1, 1);
        @(posedge i_clk);
        {i_master_role, i_two_input_mode, i_output_enable, i_output_level, i_output_level_we} <= 5'b01001;
        @(posedge i_clk);
        {i_output_enable, i_output_level_we} <= 2'b10;
        {i_master_edge_sel, i_slave_edge_sel} <= {2'h2, 2'h0};
        setup(16'h0002, 16'h0000);
        strobe(1, 1, 0, 0);
        @(posedge i_clk);
        go_m <= 1'b1;
        @(posedge i_clk);
        go_m <= 1'b0;
        fork
            measure;
            begin
                repeat (60) @(posedge i_clk);
                go_s <= 1'b1;
                @(posedge i_clk);
                go_s <= 1'b0;
            end
        join
        check(16'(d >= 4 * 4 && d <= 4 * 5 + 6), 16'h0001);
        check(16'(w >= 4 * o_slave_data && w <= 4 * o_slave_data + 8), 16'h0001);
        check(16'(o_overflow_flag), 16'h0000);
        check(o_slave_count, 16'h0000);
        @(posedge i_clk);
        {i_unit_power_enable, i_master_data, i_master_data_we} <= {1'b0, 16'h00A5, 1'b1};
        @(posedge i_clk);
        i_master_data_we <= 1'b0;
        wait_n(3);
        check(o_master_data, 16'h0000);
        check(16'(o_master_enabled), 16'h0000);
        @(posedge i_clk);
        i_unit_power_enable <= 1'b1;
        wait_n(3);
        check(o_master_data, 16'h0000);
        close_out;
    end
endmodule // pcosp_pair_bench
